// *** slpc_assertions.sv ***
module slpc_assertions
  import slpc_pkg::*;
(
  input wire logic            mclk,
  input wire logic            srst,
  input wire logic            reg_wr,
  input wire logic            key_wr,
  input wire logic [7:0]      reg_addr,
  input wire logic [7:0]      reg_wdata,
  input wire logic [7:0]      reg_rdata,
  input wire logic            insn_ret,
  input wire logic            sleep_exec,
  input wire logic            dbg_break,
  input wire logic [NSRC-1:0] wake_req,
  input wire logic            pin_async,
  input wire logic            brownout_wait,
  input wire logic            cpu_run,
  input wire logic            asleep
);
  logic [7:0] sc_q;
  logic [7:0] rc_q;
  logic       win_q;
  logic [2:0] cnt_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Shadow copies of both registers; the guarded one only moves inside an open key window.
  always_ff @(posedge mclk) begin
    if (srst) begin
      sc_q  <= 8'h00;
      rc_q  <= 8'h00;
      win_q <= 1'b0;
      cnt_q <= 3'h0;
    end else begin
      if (key_wr) begin
        win_q <= (reg_wdata == IO_REGISTER_KEY);
        cnt_q <= 3'h0;
      end else if (insn_ret && cnt_q < GUARD_INSNS) begin
        cnt_q <= cnt_q + 3'h1;
      end
      if (reg_wr && reg_addr == OFF_SLEEP_CONTROL) begin
        sc_q <= reg_wdata & SLEEP_CONTROL_MASK;
      end
      if (reg_wr && reg_addr == OFF_REGULATOR_CONTROL && win_q && cnt_q < GUARD_INSNS) begin
        rc_q  <= reg_wdata & REGULATOR_CONTROL_MASK;
        win_q <= 1'b0;
      end
    end
  end

  a_sleep_entry: assert property (sleep_exec && cpu_run && !asleep && sc_q[0]
    && sc_q[3:1] <= 3'h2 |=> asleep && !cpu_run) else $error("sleep entry not taken");
  a_sleep_needs_enable: assert property (sleep_exec && !asleep && !sc_q[0] |=> !asleep)
    else $error("slept without enable");
  a_reserved_mode: assert property (sleep_exec && !asleep && sc_q[3:1] > 3'h2 |=> !asleep)
    else $error("slept in reserved mode");
  a_idle_wake_time: assert property (asleep && sc_q[3:1] == 3'h0 && wake_req[SRC_OTHER]
    && !brownout_wait |=> (!asleep && !cpu_run) ##1 (!cpu_run)[*5] ##1 cpu_run)
    else $error("idle wake latency wrong");
  a_break_wakes: assert property (asleep && dbg_break |=> !asleep)
    else $error("debug break did not wake");
  a_frame_idle_blocked: assert property (asleep && sc_q[3:1] == 3'h0 && wake_req == 10'h080
    && !dbg_break |=> asleep) else $error("frame start woke idle");
  a_frame_stby_wakes: assert property (asleep && sc_q[3:1] == 3'h1 && wake_req[SRC_FRAME]
    |=> !asleep) else $error("frame start did not wake standby");
  a_powerdown_pin_sync: assert property (asleep && sc_q[3:1] == 3'h2 && wake_req == 10'h001
    && !pin_async && !dbg_break |=> asleep) else $error("synchronous pin woke power-down");
  a_ctrl_readback: assert property ((reg_addr == OFF_SLEEP_CONTROL && !reg_wr) ##1
    (reg_addr == OFF_SLEEP_CONTROL) |-> reg_rdata == sc_q) else $error("control readback wrong");
  a_vreg_guarded: assert property ((reg_addr == OFF_REGULATOR_CONTROL && !reg_wr) ##1
    (reg_addr == OFF_REGULATOR_CONTROL) |-> reg_rdata == rc_q)
    else $error("regulator guard broken");
endmodule

// *** slpc_dev.sv ***
module slpc_dev (
  input  wire logic                mclk,
  input  wire logic                srst,
  slpc_if.dev                      bus,
  output      logic                main_clk_on,
  output      logic                slow_clk_on,
  output      logic                vreg_low_power,
  output      logic                leak_cut_on,
  output      slpc_pkg::slpc_mode_t sleep_mode
);
  import slpc_pkg::*;

  typedef struct packed {
    slpc_state_t state;
    slpc_mode_t  mode;
    logic [7:0]  sleep_control;
    logic [7:0]  regulator_control;
    logic [2:0]  guard;
    logic [2:0]  cnt;
    logic [7:0]  rdata;
    logic        cpu_run;
    logic        asleep;
    logic        main_on;
    logic        slow_on;
    logic        vreg_low;
    logic        leak_cut;
    logic        osc_stopped;
    logic        vreg_stopped;
  } slpc_dev_t;

  slpc_dev_t s_q;
  slpc_dev_t s_d;

  logic [NSRC-1:0] allowed;
  logic            wake_any;
  logic            sleeping;
  logic [2:0]      req_mode;
  logic [2:0]      drive_sel;
  logic            hot_cut;

  // Sources that may end sleep in a given mode.
  function automatic logic [NSRC-1:0] wake_mask(
    input slpc_mode_t      m,
    input logic [NRUN-1:0] run,
    input logic            async_lut,
    input logic            async_pin,
    input logic            cut
  );
    logic [NSRC-1:0] w;
    w = '0;
    w[SRC_VOLT_MON] = 1'b1;
    w[SRC_MULTI_IO] = 1'b1;
    w[SRC_PERIODIC] = 1'b1;
    case (m)
      SLPC_IDLE: begin
        w[SRC_PIN]      = 1'b1;
        w[SRC_RTC]      = 1'b1;
        w[SRC_TWO_WIRE] = 1'b1;
        w[SRC_LOGIC]    = async_lut;
        w[SRC_TIMER]    = 1'b1;
        w[SRC_OTHER]    = 1'b1;
      end
      SLPC_STANDBY: begin
        w[SRC_PIN]      = 1'b1;
        w[SRC_RTC]      = run[RUN_RTC];
        w[SRC_TWO_WIRE] = 1'b1;
        w[SRC_LOGIC]    = async_lut & run[RUN_LOGIC];
        w[SRC_TIMER]    = run[RUN_TIMER];
        w[SRC_FRAME]    = 1'b1;
      end
      SLPC_POWER_DOWN: begin
        w[SRC_PIN]      = async_pin;
        w[SRC_TWO_WIRE] = ~cut;
        w[SRC_LOGIC]    = async_lut & ~cut;
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  // Decoded control fields and the live wake decision.
  always_comb begin
    req_mode  = s_q.sleep_control[SLEEP_MODE_LSB +: 3];
    drive_sel = s_q.regulator_control[DRIVE_SEL_LSB +: 3];
    hot_cut   = s_q.regulator_control[HOT_LEAKAGE_CUT_BIT];
    allowed   = wake_mask(s_q.mode, bus.keep_running_in_standby, bus.lut_async,
                          bus.pin_async, hot_cut);
    wake_any  = |(bus.wake_req & allowed);
  end

  // Next-state logic for registers, guard window and the sleep sequence.
  always_comb begin
    s_d = s_q;

    if (bus.key_wr && bus.reg_wdata == IO_REGISTER_KEY) begin
      s_d.guard = GUARD_INSNS;
    end else if (bus.insn_ret && s_q.guard != 3'h0) begin
      s_d.guard = s_q.guard - 3'h1;
    end

    if (bus.reg_wr && bus.reg_addr == OFF_SLEEP_CONTROL) begin
      s_d.sleep_control = bus.reg_wdata & SLEEP_CONTROL_MASK;
    end
    if (bus.reg_wr && bus.reg_addr == OFF_REGULATOR_CONTROL && s_q.guard != 3'h0) begin
      s_d.regulator_control = bus.reg_wdata & REGULATOR_CONTROL_MASK;
      s_d.guard             = 3'h0;
    end

    // Read data is registered so it appears one cycle after the address.
    case (bus.reg_addr)
      OFF_SLEEP_CONTROL:     s_d.rdata = s_q.sleep_control;
      OFF_REGULATOR_CONTROL: s_d.rdata = s_q.regulator_control;
      default:               s_d.rdata = 8'h00;
    endcase

    case (s_q.state)
      SLPC_ACTIVE: begin
        s_d.cpu_run = 1'b1;
        if (bus.sleep_exec && s_q.sleep_control[SLEEP_ENABLE_BIT] &&
            req_mode <= SLPC_POWER_DOWN) begin
          s_d.state   = SLPC_ASLEEP;
          s_d.mode    = slpc_mode_t'(req_mode);
          s_d.cpu_run = 1'b0;
        end
      end
      SLPC_ASLEEP: begin
        if (bus.dbg_break || wake_any) begin
          if (s_q.osc_stopped || s_q.vreg_stopped) begin
            s_d.state = SLPC_WAKE_CLK;
          end else begin
            s_d.state = SLPC_WAKE_CNT;
          end
          s_d.cnt = 3'h0;
        end
      end
      SLPC_WAKE_CLK: begin
        if ((!s_q.osc_stopped || bus.osc_ready) && (!s_q.vreg_stopped || bus.vreg_ready)) begin
          s_d.state = SLPC_WAKE_CNT;
          s_d.cnt   = 3'h0;
        end
      end
      SLPC_WAKE_CNT: begin
        if (s_q.cnt != WAKE_CYCLES - 3'h1) begin
          s_d.cnt = s_q.cnt + 3'h1;
        end
        if (s_q.cnt == WAKE_CYCLES - 3'h1 && (!bus.brownout_wait || bus.brownout_ready)) begin
          s_d.state   = SLPC_ACTIVE;
          s_d.cpu_run = 1'b1;
        end
      end
      default: begin
        s_d.state = SLPC_ACTIVE;
      end
    endcase

    // Clock and regulator controls follow the next state so they align with it.
    sleeping = (s_d.state == SLPC_ASLEEP);
    s_d.asleep = sleeping;
    s_d.main_on = !sleeping || s_d.mode == SLPC_IDLE ||
                  (s_d.mode == SLPC_STANDBY && bus.main_need_stby);
    s_d.slow_on = !sleeping || s_d.mode != SLPC_POWER_DOWN || bus.slow_clk_users;
    // auto drops drive on slow clock.
    s_d.vreg_low = sleeping && !s_d.main_on && drive_sel == DRIVE_AUTO && bus.low_speed_sel;
    s_d.leak_cut = sleeping && hot_cut && drive_sel == DRIVE_AUTO &&
                   s_d.mode == SLPC_POWER_DOWN;
    // What was stopped while asleep decides how long the wake takes.
    if (sleeping) begin
      s_d.osc_stopped  = !s_d.main_on;
      s_d.vreg_stopped = s_d.vreg_low;
    end else if (s_d.state == SLPC_ACTIVE) begin
      s_d.osc_stopped  = 1'b0;
      s_d.vreg_stopped = 1'b0;
    end
  end

  // State register; reset returns to active with both registers cleared.
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q                   <= '0;
      s_q.state             <= SLPC_ACTIVE;
      s_q.mode              <= SLPC_IDLE;
      s_q.sleep_control     <= SLEEP_CONTROL_RESET;
      s_q.regulator_control <= REGULATOR_CONTROL_RESET;
      s_q.cpu_run           <= 1'b1;
      s_q.main_on           <= 1'b1;
      s_q.slow_on           <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // All outputs come straight from the state register.
  assign bus.reg_rdata   = s_q.rdata;
  assign bus.cpu_run     = s_q.cpu_run;
  assign bus.asleep      = s_q.asleep;
  assign main_clk_on     = s_q.main_on;
  assign slow_clk_on     = s_q.slow_on;
  assign vreg_low_power  = s_q.vreg_low;
  assign leak_cut_on     = s_q.leak_cut;
  assign sleep_mode      = s_q.mode;

endmodule

// *** slpc_host.sv ***
module slpc_host #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              srst,
  slpc_if.host                   bus,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output      logic              arready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready
);
  import slpc_pkg::*;

  typedef struct packed {
    logic                awrdy;
    logic                wrdy;
    logic                bvalid;
    logic [1:0]          bresp;
    logic [ADDR_W-1:0]   waddr;
    logic [31:0]         wbuf;
    logic [3:0]          wstb;
    logic                arrdy;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    logic [8:0]          regw;
    logic [SRCREG_W-1:0] src;
    logic [7:0]          out_data;
    logic                sleep_exec;
    logic                dbg_break;
    logic                key_wr;
    logic                insn_ret;
    logic                reg_wr;
    logic                pend_wr;
  } slpc_host_t;

  slpc_host_t h_q;
  slpc_host_t h_d;

  logic [31:0] bmask;
  logic [31:0] stat;

  // Byte lanes to a bit mask, and the status word seen by software.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bmask[8*i +: 8] = {8{h_q.wstb[i]}};
    end
    stat = {11'h000, bus.reg_rdata, h_q.pend_wr, bus.asleep, bus.cpu_run, 10'h000};
  end

  // Next-state logic: one write and one read at a time.
  always_comb begin
    h_d = h_q;
    h_d.sleep_exec = 1'b0;
    h_d.dbg_break  = 1'b0;
    h_d.key_wr     = 1'b0;
    h_d.insn_ret   = 1'b0;
    h_d.reg_wr     = 1'b0;
    h_d.pend_wr    = 1'b0;

    if (h_q.pend_wr) begin
      h_d.reg_wr   = 1'b1;
      h_d.out_data = h_q.regw[7:0];
    end

    if (awvalid && h_q.awrdy) begin
      h_d.awrdy = 1'b0;
      h_d.waddr = awaddr;
    end
    if (wvalid && h_q.wrdy) begin
      h_d.wrdy = 1'b0;
      h_d.wbuf = wdata;
      h_d.wstb = wstrb;
    end
    if (!h_q.awrdy && !h_q.wrdy && !h_q.bvalid) begin
      h_d.bvalid = 1'b1;
      h_d.bresp  = RESP_OKAY;
      case ({h_q.waddr[ADDR_W-1:2], 2'b00})
        ADDR_W'(OFF_HOST_CMD): begin
          if (h_q.wstb[0]) begin
            h_d.sleep_exec = h_q.wbuf[CMD_SLEEP];
            h_d.dbg_break  = h_q.wbuf[CMD_BREAK];
            h_d.insn_ret   = h_q.wbuf[CMD_INSN];
            h_d.key_wr     = h_q.wbuf[CMD_KEY] | h_q.wbuf[CMD_GUARDED];
            h_d.reg_wr     = h_q.wbuf[CMD_WRITE] & ~h_q.wbuf[CMD_GUARDED];
            h_d.pend_wr    = h_q.wbuf[CMD_GUARDED];
            // A plain key command sends the staged byte, so a wrong key can be offered.
            h_d.out_data   = h_q.wbuf[CMD_GUARDED] ? IO_REGISTER_KEY : h_q.regw[7:0];
          end
        end
        ADDR_W'(OFF_HOST_REGW): begin
          h_d.regw = (h_q.regw & ~bmask[8:0]) | (h_q.wbuf[8:0] & bmask[8:0]);
        end
        ADDR_W'(OFF_HOST_SRC): begin
          h_d.src = (h_q.src & ~bmask[SRCREG_W-1:0]) |
                    (h_q.wbuf[SRCREG_W-1:0] & bmask[SRCREG_W-1:0]);
        end
        default: begin
          h_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (h_q.bvalid && bready) begin
      h_d.bvalid = 1'b0;
      h_d.awrdy  = 1'b1;
      h_d.wrdy   = 1'b1;
    end

    // Read channel: answer one cycle after the address is taken.
    if (arvalid && h_q.arrdy) begin
      h_d.arrdy  = 1'b0;
      h_d.rvalid = 1'b1;
      h_d.rresp  = RESP_OKAY;
      case ({araddr[ADDR_W-1:2], 2'b00})
        ADDR_W'(OFF_HOST_CMD):  h_d.rdata = 32'h0000_0000;
        ADDR_W'(OFF_HOST_REGW): h_d.rdata = {23'h00_0000, h_q.regw};
        ADDR_W'(OFF_HOST_SRC):  h_d.rdata = {10'h000, h_q.src};
        ADDR_W'(OFF_HOST_STAT): h_d.rdata = stat;
        default: begin
          h_d.rdata = 32'h0000_0000;
          h_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (h_q.rvalid && rready) begin
      h_d.rvalid = 1'b0;
      h_d.arrdy  = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      h_q       <= '0;
      h_q.awrdy <= 1'b1;
      h_q.wrdy  <= 1'b1;
      h_q.arrdy <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  // Bus answers and link outputs, all from the state register.
  assign awready   = h_q.awrdy;
  assign wready    = h_q.wrdy;
  assign bvalid    = h_q.bvalid;
  assign bresp     = h_q.bresp;
  assign arready   = h_q.arrdy;
  assign rvalid    = h_q.rvalid;
  assign rresp     = h_q.rresp;
  assign rdata     = h_q.rdata;
  assign bus.reg_wr     = h_q.reg_wr;
  assign bus.key_wr     = h_q.key_wr;
  assign bus.reg_addr   = {7'h00, h_q.regw[8]};
  assign bus.reg_wdata  = h_q.out_data;
  assign bus.insn_ret   = h_q.insn_ret;
  assign bus.sleep_exec = h_q.sleep_exec;
  assign bus.dbg_break  = h_q.dbg_break;
  assign bus.wake_req   = h_q.src[NSRC-1:0];
  assign bus.keep_running_in_standby = h_q.src[NSRC +: NRUN];
  assign bus.lut_async      = h_q.src[13];
  assign bus.pin_async      = h_q.src[14];
  assign bus.low_speed_sel  = h_q.src[15];
  assign bus.main_need_stby = h_q.src[16];
  assign bus.slow_clk_users = h_q.src[17];
  assign bus.osc_ready      = h_q.src[18];
  assign bus.vreg_ready     = h_q.src[19];
  assign bus.brownout_wait  = h_q.src[20];
  assign bus.brownout_ready = h_q.src[21];

endmodule

// *** slpc_if.sv ***
interface slpc_if;
  import slpc_pkg::*;

  logic            reg_wr;
  logic            key_wr;
  logic [7:0]      reg_addr;
  logic [7:0]      reg_wdata;
  logic [7:0]      reg_rdata;
  logic            insn_ret;
  logic            sleep_exec;
  logic            dbg_break;
  logic [NSRC-1:0] wake_req;
  logic [NRUN-1:0] keep_running_in_standby;
  logic            lut_async;
  logic            pin_async;
  logic            low_speed_sel;
  logic            main_need_stby;
  logic            slow_clk_users;
  logic            osc_ready;
  logic            vreg_ready;
  logic            brownout_wait;
  logic            brownout_ready;
  logic            cpu_run;
  logic            asleep;

  modport dev (
    input  reg_wr, key_wr, reg_addr, reg_wdata, insn_ret, sleep_exec,
    input  dbg_break, wake_req, keep_running_in_standby, lut_async,
    input  pin_async, low_speed_sel, main_need_stby, slow_clk_users,
    input  osc_ready, vreg_ready, brownout_wait, brownout_ready,
    output reg_rdata, cpu_run, asleep
  );

  modport host (
    output reg_wr, key_wr, reg_addr, reg_wdata, insn_ret, sleep_exec,
    output dbg_break, wake_req, keep_running_in_standby, lut_async,
    output pin_async, low_speed_sel, main_need_stby, slow_clk_users,
    output osc_ready, vreg_ready, brownout_wait, brownout_ready,
    input  reg_rdata, cpu_run, asleep
  );

endinterface

// *** slpc_pkg.sv ***
package slpc_pkg;

  // Device register offsets, layouts and reset values.
  localparam logic [7:0] OFF_SLEEP_CONTROL = 8'h00;
  localparam logic [7:0] OFF_REGULATOR_CONTROL = 8'h01;
  localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
  localparam logic [7:0] REGULATOR_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SLEEP_CONTROL_MASK = 8'h0F;
  localparam logic [7:0] REGULATOR_CONTROL_MASK = 8'h17;
  localparam int SLEEP_ENABLE_BIT = 0;
  localparam int SLEEP_MODE_LSB = 1;
  localparam int HOT_LEAKAGE_CUT_BIT = 4;
  localparam int DRIVE_SEL_LSB = 0;
  localparam logic [2:0] DRIVE_AUTO = 3'h0;
  localparam logic [2:0] DRIVE_FULL = 3'h1;

  // Unlock key value; arbitrary.
  localparam logic [7:0] IO_REGISTER_KEY = 8'h5A;
  localparam logic [2:0] GUARD_INSNS = 3'h4;
  localparam logic [2:0] WAKE_CYCLES = 3'h6;

  // Wake-up source positions.
  localparam int NSRC = 10;
  localparam int SRC_PIN = 0;
  localparam int SRC_VOLT_MON = 1;
  localparam int SRC_MULTI_IO = 2;
  localparam int SRC_RTC = 3;
  localparam int SRC_PERIODIC = 4;
  localparam int SRC_TWO_WIRE = 5;
  localparam int SRC_LOGIC = 6;
  localparam int SRC_FRAME = 7;
  localparam int SRC_TIMER = 8;
  localparam int SRC_OTHER = 9;

  // Keep-running-in-standby positions.
  localparam int NRUN = 3;
  localparam int RUN_RTC = 0;
  localparam int RUN_LOGIC = 1;
  localparam int RUN_TIMER = 2;

  // Host register map and fields.
  localparam logic [7:0] OFF_HOST_CMD = 8'h00;
  localparam logic [7:0] OFF_HOST_REGW = 8'h04;
  localparam logic [7:0] OFF_HOST_SRC = 8'h08;
  localparam logic [7:0] OFF_HOST_STAT = 8'h0C;
  localparam int CMD_SLEEP = 0;
  localparam int CMD_BREAK = 1;
  localparam int CMD_KEY = 2;
  localparam int CMD_INSN = 3;
  localparam int CMD_WRITE = 4;
  localparam int CMD_GUARDED = 5;
  localparam int NSTAT = 13;
  localparam int SRCREG_W = 22;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    SLPC_IDLE       = 3'b000,
    SLPC_STANDBY    = 3'b001,
    SLPC_POWER_DOWN = 3'b010
  } slpc_mode_t;

  typedef enum logic [1:0] {
    SLPC_ACTIVE   = 2'b00,
    SLPC_ASLEEP   = 2'b01,
    SLPC_WAKE_CLK = 2'b10,
    SLPC_WAKE_CNT = 2'b11
  } slpc_state_t;

endpackage

// *** testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import slpc_pkg::*;

  logic        mclk, srst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, cut_exp, auto_exp;
  logic [7:0]  awaddr, araddr, v;
  logic [31:0] wdata, rdata, d, base;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [65:0] e;
  logic [65:0] rq[$];
  logic [1:0]  bq[$];
  logic [9:0]  allow [0:2];
  int          fail_count, n_tests, cyc, seed;

  slpc_if slpc_if_i ();
  slpc_host slpc_host_i (.mclk(mclk), .srst(srst), .bus(slpc_if_i), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  slpc_dev slpc_dev_i (.mclk(mclk), .srst(srst), .bus(slpc_if_i), .main_clk_on(),
    .slow_clk_on(), .vreg_low_power(), .leak_cut_on(), .sleep_mode());
  slpc_assertions slpc_assertions_i (.mclk(mclk), .srst(srst), .reg_wr(slpc_if_i.reg_wr),
    .key_wr(slpc_if_i.key_wr), .reg_addr(slpc_if_i.reg_addr), .reg_wdata(slpc_if_i.reg_wdata),
    .reg_rdata(slpc_if_i.reg_rdata), .insn_ret(slpc_if_i.insn_ret),
    .sleep_exec(slpc_if_i.sleep_exec), .dbg_break(slpc_if_i.dbg_break),
    .wake_req(slpc_if_i.wake_req), .pin_async(slpc_if_i.pin_async),
    .brownout_wait(slpc_if_i.brownout_wait), .cpu_run(slpc_if_i.cpu_run),
    .asleep(slpc_if_i.asleep));

  // The clock toggles every half period of 20 ns.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Responses are judged here, oldest note first; a zero mask means the data is not judged.
  always @(posedge mclk) begin
    cyc++;
    if (bvalid === 1'b1 && bready) begin
      chk("bresp", 32'(bq.pop_front()), 32'(bresp));
    end
    if (rvalid === 1'b1 && rready) begin
      e = rq.pop_front();
      if (e[63:32] != 32'h0) chk("rdata", e[31:0], rdata & e[63:32]);
      chk("rresp", 32'(e[65:64]), 32'(rresp));
    end
    if (cyc == 30000) begin
      fail_count++;
      summarize();
    end
  end

  // Address and data are offered together and each is dropped as soon as it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
    bq.push_back(r);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= x;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
                    input logic [1:0] r, output logic [31:0] got);
    rq.push_back({r, m, x & m});
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    got = rdata;
    rready <= 1'b0;
  endtask

  task automatic cmd(input int b);
    wr(OFF_HOST_CMD, 32'h1 << b, RESP_OKAY);
  endtask

  task automatic dwrite(input logic a, input logic [7:0] x);
    wr(OFF_HOST_REGW, {23'h0, a, x}, RESP_OKAY);
    if (x !== 8'hxx) cmd(CMD_WRITE);
  endtask

  task automatic gwrite(input logic [7:0] x, input int n);
    wr(OFF_HOST_REGW, {23'h0, 1'b1, IO_REGISTER_KEY}, RESP_OKAY);
    cmd(CMD_KEY);
    repeat (n) cmd(CMD_INSN);
    dwrite(1'b1, x);
  endtask

  task automatic reg_is(input logic a, input logic [7:0] x);
    wr(OFF_HOST_REGW, {23'h0, a, 8'h00}, RESP_OKAY);
    repeat (3) @(posedge mclk);
    rd(OFF_HOST_STAT, {11'h0, x, 13'h0}, 32'h001F_E000, RESP_OKAY, d);
  endtask

  task automatic state_is(input logic run, input logic slp);
    repeat (4) @(posedge mclk);
    rd(OFF_HOST_STAT, {20'h0, slp, run, 10'h0}, 32'h0000_0C00, RESP_OKAY, d);
  endtask

  task automatic wait_run();
    d = 32'h0;
    for (int i = 0; i < 40 && d[10] !== 1'b1; i++) rd(OFF_HOST_STAT, 0, 0, RESP_OKAY, d);
    state_is(1'b1, 1'b0);
  endtask

  // A refused request is followed by a debug break, so every case ends awake.
  task automatic try_wake(input logic [2:0] m, input logic [31:0] sv, input logic ok);
    dwrite(1'b0, {4'h0, m, 1'b1});
    wr(OFF_HOST_SRC, base, RESP_OKAY);
    cmd(CMD_SLEEP);
    state_is(1'b0, 1'b1);
    chk("main_clk_on", 32'(m == 3'h0), 32'(slpc_dev_i.main_clk_on));
    chk("leak_cut_on", 32'(m == 3'h2 && cut_exp), 32'(slpc_dev_i.leak_cut_on));
    chk("sleep_mode", 32'(m), 32'(slpc_dev_i.sleep_mode));
    chk("slow_clk_on", 32'(m != 3'h2 || base[17]), 32'(slpc_dev_i.slow_clk_on));
    chk("vreg_low_power", 32'(m != 3'h0 && base[15] && auto_exp),
        32'(slpc_dev_i.vreg_low_power));
    wr(OFF_HOST_SRC, base | sv, RESP_OKAY);
    if (!ok) begin
      state_is(1'b0, 1'b1);
      cmd(CMD_BREAK);
    end
    wr(OFF_HOST_SRC, base, RESP_OKAY);
    wait_run();
  endtask

  // Main sequence.
  initial begin
    {srst, awvalid, wvalid, bready, arvalid, rready} = 6'b10_0000;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    base = 32'h000C_0000;
    allow = '{10'h33F, 10'h0B7, 10'h036};
    {fail_count, n_tests, cyc, cut_exp} = 0;
    auto_exp = 1'b1;
    seed = 32'h92c5_d925;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    reg_is(1'b0, SLEEP_CONTROL_RESET);
    reg_is(1'b1, REGULATOR_CONTROL_RESET);
    state_is(1'b1, 1'b0);
    wr(8'h10, 32'h0, RESP_SLVERR);
    rd(8'h10, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR, d);
    $display("test reset and map done");
    repeat (4) begin
      v = 8'($random(seed));
      dwrite(1'b0, v);
      reg_is(1'b0, v & SLEEP_CONTROL_MASK);
    end
    gwrite(8'h11, 3);
    reg_is(1'b1, 8'h11);
    gwrite(8'h07, 4);
    reg_is(1'b1, 8'h11);
    dwrite(1'b1, 8'h16);
    reg_is(1'b1, 8'h11);
    wr(OFF_HOST_REGW, 32'h0000_0133, RESP_OKAY);
    cmd(CMD_KEY);
    dwrite(1'b1, 8'h16);
    reg_is(1'b1, 8'h11);
    gwrite(8'hFF, 0);
    reg_is(1'b1, 8'h17);
    wr(OFF_HOST_REGW, 32'h0000_0113, RESP_OKAY);
    cmd(CMD_GUARDED);
    reg_is(1'b1, 8'h13);
    gwrite(8'h00, 0);
    $display("test register guard done");
    dwrite(1'b0, 8'h02);
    cmd(CMD_SLEEP);
    state_is(1'b1, 1'b0);
    dwrite(1'b0, 8'h07);
    cmd(CMD_SLEEP);
    state_is(1'b1, 1'b0);
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < NSRC; s++) try_wake(3'(m), 32'h1 << s, allow[m][s]);
    end
    try_wake(3'h1, 32'h0000_0408, 1'b1);
    try_wake(3'h1, 32'h0000_1100, 1'b1);
    try_wake(3'h1, 32'h0000_2840, 1'b1);
    try_wake(3'h1, 32'h0000_0840, 1'b0);
    try_wake(3'h2, 32'h0000_4001, 1'b1);
    $display("test wake sources done");
    gwrite(8'h10, 0);
    cut_exp = 1'b1;
    base = 32'h000C_8000;
    try_wake(3'h2, 32'h0000_0020, 1'b0);
    gwrite(8'h11, 0);
    cut_exp = 1'b0;
    auto_exp = 1'b0;
    try_wake(3'h2, 32'h0000_0002, 1'b1);
    gwrite(8'h00, 0);
    auto_exp = 1'b1;
    base = 32'h000C_0000;
    $display("test leakage cut done");
    base = 32'h001C_0000;
    dwrite(1'b0, 8'h01);
    wr(OFF_HOST_SRC, base, RESP_OKAY);
    cmd(CMD_SLEEP);
    wr(OFF_HOST_SRC, base | 32'h200, RESP_OKAY);
    repeat (20) @(posedge mclk);
    state_is(1'b0, 1'b0);
    base = 32'h003C_0000;
    wr(OFF_HOST_SRC, base, RESP_OKAY);
    wait_run();
    $display("test brownout wait done");
    summarize();
  end
endmodule
